// File: elapsed_counter_pkg.sv
// Purpose: Shared constants and types for the serial elapsed seconds counter
// Assumes: 25 MHz system clock, command byte sent least significant bit first
// Notes:   Bit positions refer to the assembled command byte
package elapsed_counter_pkg;

    localparam int unsigned CMD_BITS  = 8;
    localparam int unsigned DATA_BITS = 32;

    localparam int unsigned SELECT_CONTINUOUS_COUNTER = 7;
    localparam int unsigned SELECT_POWER_ON_COUNTER   = 6;
    localparam int unsigned TRIM_BIT_HIGH             = 5;
    localparam int unsigned TRIM_BIT_MID              = 4;
    localparam int unsigned TRIM_BIT_LOW              = 3;
    localparam int unsigned CLEAR_CONTINUOUS_BIT      = 2;
    localparam int unsigned CLEAR_POWER_ON_BIT        = 1;
    localparam int unsigned READ_SELECT_BIT           = 0;

    localparam logic [1:0] SEL_CONTINUOUS = 2'h2;
    localparam logic [1:0] SEL_POWER_ON   = 2'h1;
    localparam logic [1:0] SEL_TRIM       = 2'h3;
    localparam logic [1:0] SEL_CLEAR      = 2'h0;

    localparam logic [2:0] TRIM_RESET  = 3'h3;
    localparam logic [2:0] TRIM_HALT   = 3'h0;
    localparam logic [2:0] TRIM_CENTER = 3'h3;

    localparam logic [5:0] LAST_CMD_BIT  = 6'h07;
    localparam logic [5:0] LAST_DATA_BIT = 6'h1f;

    localparam int unsigned CLK_FREQ_HZ   = 25_000_000;
    localparam int unsigned TICK_PERIOD_S = 1;
    localparam int unsigned TICK_CYCLES   = CLK_FREQ_HZ * TICK_PERIOD_S;
    localparam int unsigned TRIM_STEP_CYCLES = 25;

    typedef enum logic [1:0] {
        PORT_IDLE,
        PORT_CMD,
        PORT_DATA,
        PORT_DONE
    } port_state_t;

endpackage

// File: elapsed_seconds_counter_serial.sv
// Purpose: Dual 32-bit seconds counter behind a 3-wire serial port
// Assumes: Enable, serial clock, data and power-good arrive asynchronously
// Notes:   Tick pin rises once for every second the power-on counter takes
// Operation
// - Serial port logic works only while the enable line stays high.
// - First eight rising serial clocks shift the command byte in.
// - Bits 7,6 = 10 select the continuous counter for 32 data clocks.
// - Reads snapshot the selected counter at command end and shift that out.
// - Writes buffer data and load all 32 bits at the 32nd rising edge.
// - Bits 7,6 = 01 select the power-on counter for 32 data clocks.
// - Bits 7,6 = 11 load bits 5..3 into trim, later clocks ignored.
// - Higher trim runs faster, lower slower, 000 halts, 011 is default.
// - Bit 2 clears the continuous counter when enable falls.
// - Bit 1 clears the power-on counter when enable falls; both may clear.
// - Bit 0 zero means host writes counter, one means device reads out.
// - Cycle is falling then rising edge; input bits sampled at rising.
// - Read bits appear on falling edges, first after last command bit.
// - Data pin driven only while serial clock is low during a read.
// - Enable low aborts any transfer and releases the data pin.
// - After 32 write bits further clocks ignored until enable cycles.
// - Power loss disables the port and freezes the power-on counter.
// - Continuous counter counts always; power-on counter only with power.
// - One-per-second tick output driven only while main power is present.
// - Trim leaves counters alone; other commands leave trim unchanged.
`timescale 1ns/1ps
module elapsed_seconds_counter_serial #(
    parameter int unsigned TICK_CYCLES = elapsed_counter_pkg::TICK_CYCLES,
    parameter int unsigned TRIM_STEP   = elapsed_counter_pkg::TRIM_STEP_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        enableIn,
    input  wire logic        serialClkIn,
    input  wire logic        dataIn,
    input  wire logic        mainPowerOk,
    output logic             dataOut,
    output logic             dataOe,
    output logic             tickOut,
    output logic [2:0]       trimValue
);

    if (TICK_CYCLES < 8 * TRIM_STEP + 4 || TRIM_STEP == 0) begin : g_chk
        $error("TICK_CYCLES too small for the trim step");
    end

    logic        enMeta, enS, enD;
    logic        sclkMeta, sclkS, sclkD;
    logic        dqMeta, dqS;
    logic        pwrMeta, pwrS;
    logic        rise, fall, enFall, portOn;
    elapsed_counter_pkg::port_state_t state_q;
    logic [5:0]  bitCnt_q;
    logic [7:0]  cmd_q;
    logic [7:0]  cmdNext;
    logic        cmdDone;
    logic [1:0]  selNext;
    logic [31:0] shift_q;
    logic [31:0] wrData;
    logic        wrLoad;
    logic        clrCont, clrPwr;
    logic [31:0] contCnt_q, pwrCnt_q;
    logic [2:0]  trim_q;
    logic [31:0] divCnt_q;
    logic [31:0] periodNow;
    logic        tick_q;
    logic        dataOut_q, dataOe_q, tickOut_q;

    function automatic logic [31:0] tickPeriod(input logic [2:0] trim);
        logic [31:0] up;
        logic [31:0] down;
        up   = TICK_CYCLES + 32'(elapsed_counter_pkg::TRIM_CENTER) * TRIM_STEP;
        down = 32'(trim) * TRIM_STEP;
        return up - down;
    endfunction

    // Two-stage synchronisers; third stage only for edge finding
    always_ff @(posedge clk) begin
        if (srst) begin
            enMeta   <= 1'b0;
            enS      <= 1'b0;
            enD      <= 1'b0;
            sclkMeta <= 1'b1;
            sclkS    <= 1'b1;
            sclkD    <= 1'b1;
            dqMeta   <= 1'b0;
            dqS      <= 1'b0;
            pwrMeta  <= 1'b0;
            pwrS     <= 1'b0;
        end else begin
            enMeta   <= enableIn;
            enS      <= enMeta;
            enD      <= enS;
            sclkMeta <= serialClkIn;
            sclkS    <= sclkMeta;
            sclkD    <= sclkS;
            dqMeta   <= dataIn;
            dqS      <= dqMeta;
            pwrMeta  <= mainPowerOk;
            pwrS     <= pwrMeta;
        end
    end

    assign rise    = sclkS & ~sclkD;
    assign fall    = ~sclkS & sclkD;
    assign enFall  = ~enS & enD;
    assign portOn  = enS & pwrS;
    assign cmdNext = {dqS, cmd_q[7:1]};
    assign selNext = {cmdNext[elapsed_counter_pkg::SELECT_CONTINUOUS_COUNTER],
                      cmdNext[elapsed_counter_pkg::SELECT_POWER_ON_COUNTER]};
    assign cmdDone = portOn && state_q == elapsed_counter_pkg::PORT_CMD && rise
                     && bitCnt_q == elapsed_counter_pkg::LAST_CMD_BIT;
    assign wrData  = {dqS, shift_q[31:1]};
    assign wrLoad  = portOn && state_q == elapsed_counter_pkg::PORT_DATA && rise
                     && bitCnt_q == elapsed_counter_pkg::LAST_DATA_BIT
                     && !cmd_q[elapsed_counter_pkg::READ_SELECT_BIT];
    // Clears only after a complete clear-type command
    assign clrCont = enFall && pwrS && state_q == elapsed_counter_pkg::PORT_DONE
                     && cmd_q[7:6] == elapsed_counter_pkg::SEL_CLEAR
                     && cmd_q[elapsed_counter_pkg::CLEAR_CONTINUOUS_BIT];
    assign clrPwr  = enFall && pwrS && state_q == elapsed_counter_pkg::PORT_DONE
                     && cmd_q[7:6] == elapsed_counter_pkg::SEL_CLEAR
                     && cmd_q[elapsed_counter_pkg::CLEAR_POWER_ON_BIT];

    // Transfer sequencing
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q  <= elapsed_counter_pkg::PORT_IDLE;
            bitCnt_q <= 6'h00;
        end else if (!portOn) begin
            state_q  <= elapsed_counter_pkg::PORT_IDLE;
            bitCnt_q <= 6'h00;
        end else begin
            case (state_q)
                elapsed_counter_pkg::PORT_IDLE: begin
                    state_q  <= elapsed_counter_pkg::PORT_CMD;
                    bitCnt_q <= 6'h00;
                end
                elapsed_counter_pkg::PORT_CMD: begin
                    if (cmdDone) begin
                        bitCnt_q <= 6'h00;
                        if (selNext == elapsed_counter_pkg::SEL_CONTINUOUS ||
                            selNext == elapsed_counter_pkg::SEL_POWER_ON) begin
                            state_q <= elapsed_counter_pkg::PORT_DATA;
                        end else begin
                            state_q <= elapsed_counter_pkg::PORT_DONE;
                        end
                    end else if (rise) begin
                        bitCnt_q <= bitCnt_q + 6'h01;
                    end
                end
                elapsed_counter_pkg::PORT_DATA: begin
                    if (rise) begin
                        if (bitCnt_q == elapsed_counter_pkg::LAST_DATA_BIT) begin
                            state_q <= elapsed_counter_pkg::PORT_DONE;
                        end else begin
                            bitCnt_q <= bitCnt_q + 6'h01;
                        end
                    end
                end
                elapsed_counter_pkg::PORT_DONE: begin
                    state_q <= elapsed_counter_pkg::PORT_DONE;
                end
                default: begin
                    state_q <= elapsed_counter_pkg::PORT_IDLE;
                end
            endcase
        end
    end

    // Command and data shift registers
    always_ff @(posedge clk) begin
        if (srst) begin
            cmd_q   <= 8'h00;
            shift_q <= 32'h0000_0000;
        end else if (portOn && state_q == elapsed_counter_pkg::PORT_CMD && rise) begin
            cmd_q <= cmdNext;
            if (cmdDone) begin
                if (selNext == elapsed_counter_pkg::SEL_CONTINUOUS) begin
                    shift_q <= contCnt_q;
                end else begin
                    shift_q <= pwrCnt_q;
                end
            end
        end else if (portOn && state_q == elapsed_counter_pkg::PORT_DATA) begin
            if (cmd_q[elapsed_counter_pkg::READ_SELECT_BIT]) begin
                if (fall) begin
                    shift_q <= {1'b0, shift_q[31:1]};
                end
            end else if (rise) begin
                shift_q <= wrData;
            end
        end
    end

    // Data pin: driven from falling edge to next rising edge
    always_ff @(posedge clk) begin
        if (srst) begin
            dataOut_q <= 1'b0;
            dataOe_q  <= 1'b0;
        end else if (!portOn || state_q != elapsed_counter_pkg::PORT_DATA
                     || !cmd_q[elapsed_counter_pkg::READ_SELECT_BIT]) begin
            dataOe_q  <= 1'b0;
        end else if (fall) begin
            dataOut_q <= shift_q[0];
            dataOe_q  <= 1'b1;
        end else if (rise) begin
            dataOe_q  <= 1'b0;
        end
    end

    // Oscillator trim
    always_ff @(posedge clk) begin
        if (srst) begin
            trim_q <= elapsed_counter_pkg::TRIM_RESET;
        end else if (cmdDone && selNext == elapsed_counter_pkg::SEL_TRIM) begin
            trim_q <= cmdNext[elapsed_counter_pkg::TRIM_BIT_HIGH:
                              elapsed_counter_pkg::TRIM_BIT_LOW];
        end
    end

    // Seconds divider; period shrinks as trim rises
    assign periodNow = tickPeriod(trim_q);
    always_ff @(posedge clk) begin
        if (srst) begin
            divCnt_q <= 32'h0000_0000;
            tick_q   <= 1'b0;
        end else if (trim_q == elapsed_counter_pkg::TRIM_HALT) begin
            tick_q   <= 1'b0;
        end else if (divCnt_q >= periodNow - 32'h1) begin
            divCnt_q <= 32'h0000_0000;
            tick_q   <= 1'b1;
        end else begin
            divCnt_q <= divCnt_q + 32'h1;
            tick_q   <= 1'b0;
        end
    end

    // Rises only on a tick, so no partial pulse after power return or restart
    always_ff @(posedge clk) begin
        if (srst) begin
            tickOut_q <= 1'b0;
        end else if (!pwrS) begin
            tickOut_q <= 1'b0;
        end else if (tick_q) begin
            tickOut_q <= 1'b1;
        end else if (trim_q == elapsed_counter_pkg::TRIM_HALT
                     || divCnt_q >= (periodNow >> 1)) begin
            tickOut_q <= 1'b0;
        end
    end

    // Seconds counters; writes and clears win over a tick
    always_ff @(posedge clk) begin
        if (srst) begin
            contCnt_q <= 32'h0000_0000;
        end else if (clrCont) begin
            contCnt_q <= 32'h0000_0000;
        end else if (wrLoad && cmd_q[7:6] == elapsed_counter_pkg::SEL_CONTINUOUS) begin
            contCnt_q <= wrData;
        end else if (tick_q) begin
            contCnt_q <= contCnt_q + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pwrCnt_q <= 32'h0000_0000;
        end else if (clrPwr) begin
            pwrCnt_q <= 32'h0000_0000;
        end else if (wrLoad && cmd_q[7:6] == elapsed_counter_pkg::SEL_POWER_ON) begin
            pwrCnt_q <= wrData;
        end else if (tick_q && pwrS) begin
            pwrCnt_q <= pwrCnt_q + 32'h1;
        end
    end

    assign dataOut   = dataOut_q;
    assign dataOe    = dataOe_q;
    assign tickOut   = tickOut_q;
    assign trimValue = trim_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    sequence sReadStart;
        cmdDone && cmdNext[elapsed_counter_pkg::READ_SELECT_BIT]
            && selNext == elapsed_counter_pkg::SEL_CONTINUOUS;
    endsequence

    sequence sFirstReadFall;
        portOn && fall && state_q == elapsed_counter_pkg::PORT_DATA
            && cmd_q[elapsed_counter_pkg::READ_SELECT_BIT] && bitCnt_q == 6'h00;
    endsequence

    sequence sTrimCmd;
        cmdDone && selNext == elapsed_counter_pkg::SEL_TRIM;
    endsequence

    a_oe_clk_high: assert property ($rose(sclkS) |=> !dataOe_q)
        else $error("data pin driven while serial clock high");
    a_enable_low_release: assert property (!enS |=> !dataOe_q)
        else $error("data pin driven after enable low");
    a_trim_load: assert property (sTrimCmd |=> trim_q == $past(cmdNext[5:3]))
        else $error("trim not loaded from command");
    a_trim_kept: assert property (
        cmdDone && selNext != elapsed_counter_pkg::SEL_TRIM |=> $stable(trim_q))
        else $error("trim changed by non-trim command");
    a_snapshot_taken: assert property (sReadStart |=> shift_q == $past(contCnt_q))
        else $error("read snapshot differs from counter");
    a_write_load: assert property (
        wrLoad && cmd_q[7:6] == elapsed_counter_pkg::SEL_CONTINUOUS && !clrCont
        |=> contCnt_q == $past(wrData))
        else $error("write data not loaded");
    a_clear_cont: assert property (clrCont |=> contCnt_q == 32'h0000_0000)
        else $error("continuous counter not cleared");
    a_power_hold: assert property (!pwrS |=> $stable(pwrCnt_q))
        else $error("power-on counter moved without power");
    a_cont_count: assert property (
        tick_q && !clrCont && !wrLoad |=> contCnt_q == $past(contCnt_q) + 32'h1)
        else $error("continuous counter missed a tick");
    a_tick_off: assert property (!pwrS |=> !tickOut_q)
        else $error("tick output active without power");
    a_done_ignores: assert property (
        state_q == elapsed_counter_pkg::PORT_DONE && enS && pwrS ##1 enS && pwrS
        |-> state_q == elapsed_counter_pkg::PORT_DONE)
        else $error("clocks not ignored after transfer end");
    a_first_read_bit: assert property (
        sFirstReadFall |=> dataOe_q && dataOut_q == $past(shift_q[0]))
        else $error("first read bit not presented on falling edge");

endmodule

// File: serial_host_model.sv
// Purpose: Host side of the 3-wire counter port
// Assumes: Clock idles high, each half bit lasts 4 clk (320 ns bit)
// Notes:   Host releases its data drive after the rising edge hold time
`timescale 1ns/1ps
module serial_host_model (
    input  wire logic clk,
    input  wire logic dq,
    output logic      enableIn,
    output logic      serialClkIn,
    output logic      hostBit,
    output logic      hostOe
);
    initial begin
        enableIn    = 1'b0;
        serialClkIn = 1'b1;
        hostBit     = 1'b0;
        hostOe      = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Falling edge, data set, sample while low, rising edge, release
    task automatic clock_bit(input logic drive, input logic b, output logic s);
        serialClkIn = 1'b0;
        hostOe      = drive;
        hostBit     = b;
        wait_clk(4);
        s           = dq;
        serialClkIn = 1'b1;
        wait_clk(2);
        hostOe      = 1'b0;
        wait_clk(2);
    endtask

    task automatic xfer(input logic [7:0] cmd, input logic [31:0] wd, input int n,
                        output logic [31:0] rd);
        logic s;
        logic rdMode;
        rdMode   = cmd[0] && (cmd[7] ^ cmd[6]);
        rd       = 32'h0;
        enableIn = 1'b1;
        wait_clk(4);
        for (int i = 0; i < 8; i++) clock_bit(1'b1, cmd[i], s);
        for (int i = 0; i < n; i++) begin
            clock_bit(!rdMode, (i < 32) ? wd[i] : !wd[i % 32], s);
            if (i < 32) rd[i] = s;
        end
        wait_clk(2);
        enableIn = 1'b0;
        wait_clk(30);
    endtask
endmodule

// File: elapsed_seconds_counter_serial_test.sv
// Purpose: Self-checking bench for the serial elapsed seconds counter
// Assumes: Shortened second of 400 clk, trim step of 4 clk
// Notes:   Counters are compared with the oscillator halted
`timescale 1ns/1ps
module elapsed_seconds_counter_serial_test;
    localparam int unsigned TICKS = 400;
    localparam int unsigned STEP  = 4;
    logic        clk         = 1'b0;
    logic        srst        = 1'b1;
    logic        mainPowerOk = 1'b1;
    logic        lastDq      = 1'b0;
    logic        tickPrev    = 1'b0;
    logic        enableIn, serialClkIn, hostBit, hostOe, dataOut, dataOe, tickOut, dq;
    logic [2:0]  trimValue;
    logic [31:0] rd;
    int unsigned rises       = 0;
    int unsigned cyc         = 0;
    int          errors      = 0;
    int          n_checks    = 0;

    elapsed_seconds_counter_serial #(.TICK_CYCLES(TICKS), .TRIM_STEP(STEP)) u_dut (
        .clk(clk), .srst(srst), .enableIn(enableIn), .serialClkIn(serialClkIn),
        .dataIn(dq), .mainPowerOk(mainPowerOk), .dataOut(dataOut), .dataOe(dataOe),
        .tickOut(tickOut), .trimValue(trimValue));
    serial_host_model u_host (.clk(clk), .dq(dq), .enableIn(enableIn),
        .serialClkIn(serialClkIn), .hostBit(hostBit), .hostOe(hostOe));

    // Released line shows a pattern that changes every cycle
    assign dq = (dataOe === 1'b1) ? dataOut : (hostOe ? hostBit : !lastDq);

    always #20 clk = ~clk;

    always @(posedge clk) begin
        lastDq   <= dq;
        tickPrev <= tickOut;
        if (tickOut === 1'b1 && tickPrev === 1'b0) rises <= rises + 1;
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            conclude();
        end
    end

    task automatic conclude();
        if (errors == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic run(input logic [7:0] c, input logic [31:0] w, input int n);
        u_host.xfer(c, w, n, rd);
    endtask

    task automatic expect_read(input logic [7:0] c, input logic [31:0] e);
        run(c, 32'h0, 32);
        check(rd, e);
    endtask

    // Cycles between two tick rises, first full interval skipped
    task automatic measure(output logic [31:0] p);
        int unsigned r0;
        int unsigned c0;
        for (int k = 0; k < 3; k++) begin
            if (k == 2) c0 = cyc;
            r0 = rises;
            while (rises == r0) step(1);
        end
        p = cyc - c0;
    endtask

    initial begin
        logic [31:0] p;
        int unsigned r0;
        int unsigned r1;
        step(5);
        srst = 1'b0;
        step(6);
        check(32'(trimValue), 32'h3);
        check(32'(dataOe), 32'h0);
        measure(p);
        check(p, TICKS);
        for (int t = 7; t > 0; t -= 6) begin
            run({2'h3, 3'(t), 3'h0}, 32'h0, 0);
            check(32'(trimValue), 32'(t));
            measure(p);
            check(p, 32'(TICKS + (3 - t) * STEP));
        end
        run(8'hc0, 32'h0, 0);
        run(8'h80, 32'h8badf00d, 32);
        run(8'h40, 32'h12345678, 32);
        run(8'hc6, 32'h0, 0);
        check(32'(trimValue), 32'h0);
        step(600);
        check(32'(tickOut), 32'h0);
        expect_read(8'h81, 32'h8badf00d);
        expect_read(8'h41, 32'h12345678);
        run(8'h80, 32'h00c0ffee, 40);
        expect_read(8'h81, 32'h00c0ffee);
        run(8'h80, 32'hffffffff, 16);
        check(32'(dataOe), 32'h0);
        run(8'h41, 32'h0, 10);
        check(rd, 32'h00000278);
        check(32'(dataOe), 32'h0);
        expect_read(8'h81, 32'h00c0ffee);
        run(8'h04, 32'h0, 0);
        expect_read(8'h81, 32'h0);
        expect_read(8'h41, 32'h12345678);
        run(8'h02, 32'h0, 0);
        expect_read(8'h41, 32'h0);
        run(8'h80, 32'h1, 32);
        run(8'h40, 32'h2, 32);
        run(8'h06, 32'h0, 0);
        expect_read(8'h81, 32'h0);
        expect_read(8'h41, 32'h0);
        check(32'(trimValue), 32'h0);
        // Run, then halt, and compare with the ticks seen
        r0 = rises;
        run(8'hd8, 32'h0, 0);
        step(1000);
        run(8'hc0, 32'h0, 0);
        expect_read(8'h81, rises - r0);
        expect_read(8'h41, rises - r0);
        // Power loss: port refused, tick gone, power-on count frozen
        run(8'h06, 32'h0, 0);
        r0 = rises;
        run(8'hd8, 32'h0, 0);
        step(500);
        mainPowerOk = 1'b0;
        step(5);
        r1 = rises;
        run(8'h80, 32'h55555555, 32);
        step(700);
        check(rises - r1, 32'h0);
        mainPowerOk = 1'b1;
        step(10);
        run(8'hc0, 32'h0, 0);
        expect_read(8'h41, rises - r0);
        r1 = rd;
        run(8'h81, 32'h0, 32);
        check(32'(rd > r1), 32'h1);
        check(32'(rd < 32'h100), 32'h1);
        conclude();
    end
endmodule
